// file: panel_status.sv
// Front-panel control state and status reporting registers
//
// Functional notes
// - Panel state Local/Remote/Lockout coded 0,1,2, set by state command.
// - Local state accepts remote commands and all front-panel input.
// - Remote ignores keys and knob except Local key, which returns to Local.
// - Local Lockout ignores every front-panel input, Local key included.
// - Remote indicator lit in Remote or Lockout, off in Local, override aside.
// - Override flag defaults on; while on the front panel stays fully active.
// - State query first moves Local to Remote, so it answers 1 or 2.
// - Clear-status zeroes all status registers, leaves enable masks alone.
// - Serial poll status read whole or one bit, no bit altered.
// - Status-byte read never shows interface-ready bit 1; only serial poll does.
// - Serial poll enable written whole or per bit, read back either way.
// - Standard event whole read clears all; bit read clears only that bit.
// - Standard event enable written and read whole or per bit.
// - Power-on clear flag 1 clears masks at power-on; 0 keeps them.
// - Error register whole read clears all; bit read clears only that bit.
// - Error enable written and read whole or per bit.
// - Lock-in status whole read clears all; bit read clears that bit.
// - Lock-in enable written and read whole or per bit.
// - Poll bits 2,3,5 summarise enabled error, lock-in, event bits.
// - Event and error bits latch until read or cleared.
`timescale 1ns/1ps
`include "panel_status_cfg.svh"

module panel_status
    import panel_status_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic COLD_RESETN,
    input wire logic CE,
    input wire cmd_s CMD,
    input wire logic CMD_VALID,
    input wire event_src_s EVT,
    input wire logic SCAN_IDLE,
    input wire logic IFACE_READY,
    input wire logic OUT_AVAIL,
    input wire logic KEY_PIN,
    input wire logic KNOB_PIN,
    input wire logic LOCAL_KEY_PIN,
    output logic RSP_VALID,
    output logic [15:0] RSP_DATA,
    output logic [7:0] SPOLL_BYTE,
    output logic SRQ,
    output logic REMOTE_LED,
    output logic PANEL_ACTIVE,
    output logic KEY_ACCEPT
);

    // Whole or single-bit readback, bit in the low position
    function automatic logic [15:0] read_sel(input logic [15:0] v, input logic bf,
                                             input logic [3:0] i);
        read_sel = bf ? {15'h0000, v[i]} : v;
    endfunction

    // Bits a read clears: all, or just the addressed one
    function automatic logic [15:0] clr_sel(input logic bf, input logic [3:0] i);
        clr_sel = bf ? (16'h0001 << i) : 16'hffff;
    endfunction

    // Whole write, or one addressed bit set to the low data bit
    function automatic logic [15:0] write_sel(input logic [15:0] old, input logic bf,
                                              input logic [3:0] i, input logic [15:0] d);
        logic [15:0] v;
        v = old;
        if (bf) begin
            v[i] = d[0];
        end else begin
            v = d;
        end
        write_sel = v;
    endfunction

    function automatic logic [1:0] state_code(input panel_state_e s);
        case (s)
            ST_REMOTE: state_code = `PSR_STATE_REMOTE;
            ST_LOCKOUT: state_code = `PSR_STATE_LOCKOUT;
            default: state_code = `PSR_STATE_LOCAL;
        endcase
    endfunction

    panel_state_e state_r;
    panel_state_e state_nxt;
    logic ovr_r;
    logic psc_r;
    logic [7:0] sre_r;
    logic [7:0] ese_r;
    logic [7:0] error_enable_r;
    logic [15:0] lockin_enable_cmd_r;
    logic [7:0] esr_r;
    logic [7:0] esr_nxt;
    logic [7:0] err_r;
    logic [7:0] err_nxt;
    logic [15:0] lia_r;
    logic [15:0] lia_nxt;
    logic [2:0] pin_meta_r;
    logic [2:0] pin_sync_r;
    logic [2:0] pin_prev_r;
    logic key_evt;
    logic knob_evt;
    logic local_evt;
    logic panel_on;
    logic local_take;
    logic [7:0] spoll;
    logic [15:0] rsp_nxt;
    logic cmd_go;

    assign cmd_go = CE && CMD_VALID;

    // Panel pins are asynchronous; two stages before any edge detect
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            pin_meta_r <= 3'h0;
            pin_sync_r <= 3'h0;
            pin_prev_r <= 3'h0;
        end else if (CE) begin
            pin_meta_r <= {LOCAL_KEY_PIN, KNOB_PIN, KEY_PIN};
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    assign key_evt = pin_sync_r[0] && !pin_prev_r[0];
    assign knob_evt = pin_sync_r[1] && !pin_prev_r[1];
    assign local_evt = pin_sync_r[2] && !pin_prev_r[2];

    assign panel_on = ovr_r || (state_r == ST_LOCAL);
    assign local_take = local_evt && (panel_on || state_r == ST_REMOTE);

    always_comb begin
        state_nxt = state_r;
        if (local_take) begin
            state_nxt = ST_LOCAL;
        end
        if (cmd_go && CMD.op == OP_STATE_SET) begin
            case (CMD.data[1:0])
                `PSR_STATE_LOCAL: state_nxt = ST_LOCAL;
                `PSR_STATE_REMOTE: state_nxt = ST_REMOTE;
                `PSR_STATE_LOCKOUT: state_nxt = ST_LOCKOUT;
                default: state_nxt = state_r;
            endcase
        end else if (cmd_go && CMD.op == OP_STATE_Q && state_r == ST_LOCAL) begin
            state_nxt = ST_REMOTE;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state_r <= ST_LOCAL;
        end else if (CE) begin
            state_r <= state_nxt;
        end
    end

    // Override and power-on clear flag sit in the backed-up store
    always_ff @(posedge CLK) begin
        if (!COLD_RESETN) begin
            ovr_r <= `PSR_OVR_DEFAULT;
            psc_r <= 1'b1;
        end else if (cmd_go) begin
            if (CMD.op == OP_OVR_SET) begin
                ovr_r <= CMD.data[0];
            end
            if (CMD.op == OP_PSC_SET) begin
                psc_r <= CMD.data[0];
            end
        end
    end

    // enable masks, kept over power-on when flag is 0
    always_ff @(posedge CLK) begin
        if (!COLD_RESETN || (!RESETN && psc_r)) begin
            sre_r <= 8'h00;
            ese_r <= 8'h00;
            error_enable_r <= 8'h00;
            lockin_enable_cmd_r <= 16'h0000;
        end else if (RESETN && cmd_go) begin
            case (CMD.op)
                OP_SRE_SET: sre_r <= 8'(write_sel({8'h00, sre_r}, CMD.bit_form,
                                                  {1'b0, CMD.idx[2:0]}, CMD.data));
                OP_ESE_SET: ese_r <= 8'(write_sel({8'h00, ese_r}, CMD.bit_form,
                                                  {1'b0, CMD.idx[2:0]}, CMD.data));
                OP_ERROR_ENABLE_SET: error_enable_r <= 8'(write_sel({8'h00, error_enable_r}, CMD.bit_form,
                                                    {1'b0, CMD.idx[2:0]}, CMD.data));
                OP_LOCKIN_ENABLE_CMD_SET: lockin_enable_cmd_r <= write_sel(lockin_enable_cmd_r, CMD.bit_form, CMD.idx, CMD.data);
                default: ;
            endcase
        end
    end

    // sticky bits; a new event beats a clearing read
    always_comb begin
        esr_nxt = esr_r;
        err_nxt = err_r;
        lia_nxt = lia_r;
        if (cmd_go) begin
            case (CMD.op)
                OP_CLS: begin
                    esr_nxt = 8'h00;
                    err_nxt = 8'h00;
                    lia_nxt = 16'h0000;
                end
                OP_ESR_Q: esr_nxt = esr_r & ~8'(clr_sel(CMD.bit_form, {1'b0, CMD.idx[2:0]}));
                OP_ERR_Q: err_nxt = err_r & ~8'(clr_sel(CMD.bit_form, {1'b0, CMD.idx[2:0]}));
                OP_LIA_Q: lia_nxt = lia_r & ~clr_sel(CMD.bit_form, CMD.idx);
                default: ;
            endcase
        end
        esr_nxt = esr_nxt | EVT.event_set;
        esr_nxt[`PSR_ESR_URQ_BIT] = esr_nxt[`PSR_ESR_URQ_BIT]
            | (panel_on && (key_evt || knob_evt));
        err_nxt = err_nxt | EVT.error_set;
        lia_nxt = lia_nxt | EVT.lockin_set;
    end

    // Power-on flags a power-on event so it can raise a request
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            esr_r <= `PSR_ESR_PON_VAL;
            err_r <= 8'h00;
            lia_r <= 16'h0000;
        end else if (CE) begin
            esr_r <= esr_nxt;
            err_r <= err_nxt;
            lia_r <= lia_nxt;
        end
    end

    always_comb begin
        spoll = 8'h00;
        spoll[`PSR_SP_SCAN_BIT] = SCAN_IDLE;
        spoll[`PSR_SP_IFACE_BIT] = IFACE_READY;
        spoll[`PSR_SP_ERR_BIT] = |(err_r & error_enable_r);
        spoll[`PSR_SP_LOCKIN_BIT] = |(lia_r & lockin_enable_cmd_r);
        spoll[`PSR_SP_MAV_BIT] = OUT_AVAIL;
        spoll[`PSR_SP_EVENT_BIT] = |(esr_r & ese_r);
        spoll[`PSR_SP_SRQ_BIT] = |(spoll & sre_r & ~(8'h01 << `PSR_SP_SRQ_BIT));
    end

    // command answers, taken from values before any clear
    always_comb begin
        case (CMD.op)
            OP_STATE_Q: rsp_nxt = {14'h0000, (state_r == ST_LOCAL) ? `PSR_STATE_REMOTE
                                                                     : state_code(state_r)};
            OP_OVR_Q: rsp_nxt = {15'h0000, ovr_r};
            OP_PSC_Q: rsp_nxt = {15'h0000, psc_r};
            OP_STB_Q: rsp_nxt = read_sel({8'h00, spoll & `PSR_SP_READ_MASK}, CMD.bit_form,
                                         {1'b0, CMD.idx[2:0]});
            OP_SRE_Q: rsp_nxt = read_sel({8'h00, sre_r}, CMD.bit_form, {1'b0, CMD.idx[2:0]});
            OP_ESR_Q: rsp_nxt = read_sel({8'h00, esr_r}, CMD.bit_form, {1'b0, CMD.idx[2:0]});
            OP_ESE_Q: rsp_nxt = read_sel({8'h00, ese_r}, CMD.bit_form, {1'b0, CMD.idx[2:0]});
            OP_ERR_Q: rsp_nxt = read_sel({8'h00, err_r}, CMD.bit_form, {1'b0, CMD.idx[2:0]});
            OP_ERROR_ENABLE_Q: rsp_nxt = read_sel({8'h00, error_enable_r}, CMD.bit_form, {1'b0, CMD.idx[2:0]});
            OP_LIA_Q: rsp_nxt = read_sel(lia_r, CMD.bit_form, CMD.idx);
            OP_LOCKIN_ENABLE_CMD_Q: rsp_nxt = read_sel(lockin_enable_cmd_r, CMD.bit_form, CMD.idx);
            default: rsp_nxt = 16'h0000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            RSP_VALID <= 1'b0;
            RSP_DATA <= 16'h0000;
        end else if (CE) begin
            RSP_VALID <= CMD_VALID && CMD.op inside {OP_STATE_Q, OP_OVR_Q, OP_PSC_Q,
                OP_STB_Q, OP_SRE_Q, OP_ESR_Q, OP_ESE_Q, OP_ERR_Q, OP_ERROR_ENABLE_Q,
                OP_LIA_Q, OP_LOCKIN_ENABLE_CMD_Q};
            RSP_DATA <= CMD_VALID ? rsp_nxt : 16'h0000;
        end
    end

    // indicator and panel-active outputs follow the next state; key accept follows the current state
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            REMOTE_LED <= 1'b0;
            PANEL_ACTIVE <= 1'b1;
            KEY_ACCEPT <= 1'b0;
            SPOLL_BYTE <= 8'h00;
            SRQ <= 1'b0;
        end else if (CE) begin
            REMOTE_LED <= (state_nxt != ST_LOCAL);
            PANEL_ACTIVE <= ovr_r || (state_nxt == ST_LOCAL);
            KEY_ACCEPT <= panel_on && (key_evt || knob_evt);
            SPOLL_BYTE <= spoll;
            SRQ <= spoll[`PSR_SP_SRQ_BIT];
        end
    end

    // Indicator tracks state whatever the override
    AST_LED: assert property (@(posedge CLK) disable iff (!RESETN || !CE)
        $past(RESETN) && $past(CE) |-> REMOTE_LED == (state_r != ST_LOCAL))
        else $error("remote indicator disagrees with state");

    // Query from Local moves to Remote and answers one
    AST_QUERY: assert property (@(posedge CLK) disable iff (!RESETN || !CE)
        CMD_VALID && CMD.op == OP_STATE_Q && state_r == ST_LOCAL && !local_take
        |=> state_r == ST_REMOTE && RSP_VALID && RSP_DATA == 16'h0001)
        else $error("state query did not force remote");

    // Lockout without override ignores every panel input
    AST_LOCKOUT: assert property (@(posedge CLK) disable iff (!RESETN || !CE)
        state_r == ST_LOCKOUT && !ovr_r && !(CMD_VALID && CMD.op == OP_STATE_SET)
        |=> state_r == ST_LOCKOUT && !KEY_ACCEPT)
        else $error("panel input acted in lockout");

    // Local key in Remote returns to Local
    AST_LOCAL_KEY: assert property (@(posedge CLK) disable iff (!RESETN || !CE)
        state_r == ST_REMOTE && local_evt && !CMD_VALID |=> state_r == ST_LOCAL)
        else $error("local key ignored in remote");

    // Clear-status zeroes status, keeps serial poll and lock-in enable masks
    AST_CLS: assert property (@(posedge CLK) disable iff (!RESETN || !CE)
        CMD_VALID && CMD.op == OP_CLS && EVT == '0 && !key_evt && !knob_evt
        |=> esr_r == 8'h00 && err_r == 8'h00 && lia_r == 16'h0000
            && $stable(sre_r) && $stable(lockin_enable_cmd_r))
        else $error("clear status wrong");

    // Status-byte answer never shows interface ready
    AST_STB: assert property (@(posedge CLK) disable iff (!RESETN || !CE)
        CMD_VALID && CMD.op == OP_STB_Q && !CMD.bit_form
        |=> RSP_DATA[`PSR_SP_IFACE_BIT] == 1'b0 && RSP_VALID)
        else $error("status byte leaked interface ready");

    // Whole error read clears it
    AST_ERR_CLR: assert property (@(posedge CLK) disable iff (!RESETN || !CE)
        CMD_VALID && CMD.op == OP_ERR_Q && !CMD.bit_form && EVT.error_set == 8'h00
        |=> err_r == 8'h00 && RSP_DATA == {8'h00, $past(err_r)})
        else $error("error read did not clear");

    // Lock-in bit read clears only that bit
    AST_LIA_BIT: assert property (@(posedge CLK) disable iff (!RESETN || !CE)
        CMD_VALID && CMD.op == OP_LIA_Q && CMD.bit_form && EVT.lockin_set == 16'h0000
        |=> lia_r == ($past(lia_r) & ~(16'h0001 << $past(CMD.idx))))
        else $error("lock-in bit read wrong");

    // Events latch even against a clearing read
    AST_LATCH: assert property (@(posedge CLK) disable iff (!RESETN || !CE)
        EVT.event_set[0] |=> esr_r[0] ##1 (esr_r[0] || $past(cmd_go)))
        else $error("event bit lost");

    // Summary bit follows enabled event bits
    AST_SUMMARY: assert property (@(posedge CLK) disable iff (!RESETN || !CE)
        $past(CE) && $past(RESETN) |->
        SPOLL_BYTE[`PSR_SP_EVENT_BIT] == |($past(esr_r) & $past(ese_r)))
        else $error("event summary wrong");

endmodule // panel_status

// file: panel_status_cfg.svh
// Constants for the panel control and status reporting block
`ifndef PANEL_STATUS_CFG_SVH
`define PANEL_STATUS_CFG_SVH

`define PSR_STATE_LOCAL 2'h0
`define PSR_STATE_REMOTE 2'h1
`define PSR_STATE_LOCKOUT 2'h2
`define PSR_OVR_DEFAULT 1'h1
`define PSR_ESR_PON_VAL 8'h80
`define PSR_ESR_URQ_BIT 6
`define PSR_SP_SCAN_BIT 0
`define PSR_SP_IFACE_BIT 1
`define PSR_SP_ERR_BIT 2
`define PSR_SP_LOCKIN_BIT 3
`define PSR_SP_MAV_BIT 4
`define PSR_SP_EVENT_BIT 5
`define PSR_SP_SRQ_BIT 6
`define PSR_SP_READ_MASK 8'hfd

`endif

// file: panel_status_pkg.sv
// Types for the panel control and status reporting block
package panel_status_pkg;

    typedef enum logic [4:0] {
        OP_NONE,
        OP_STATE_SET,
        OP_STATE_Q,
        OP_OVR_SET,
        OP_OVR_Q,
        OP_CLS,
        OP_STB_Q,
        OP_SRE_SET,
        OP_SRE_Q,
        OP_ESR_Q,
        OP_ESE_SET,
        OP_ESE_Q,
        OP_PSC_SET,
        OP_PSC_Q,
        OP_ERR_Q,
        OP_ERROR_ENABLE_SET,
        OP_ERROR_ENABLE_Q,
        OP_LIA_Q,
        OP_LOCKIN_ENABLE_CMD_SET,
        OP_LOCKIN_ENABLE_CMD_Q
    } cmd_op_e;

    typedef enum logic [1:0] {
        ST_LOCAL,
        ST_REMOTE,
        ST_LOCKOUT
    } panel_state_e;

    typedef struct packed {
        cmd_op_e op;
        logic bit_form;
        logic [3:0] idx;
        logic [15:0] data;
    } cmd_s;

    typedef struct packed {
        logic [7:0] event_set;
        logic [7:0] error_set;
        logic [15:0] lockin_set;
    } event_src_s;

endpackage

// file: host_model.sv
// Remote host model issuing commands on the command port
`timescale 1ns/1ps
module host_model
    import panel_status_pkg::*;
(
    input wire logic CLK,
    output cmd_s CMD,
    output logic CMD_VALID,
    input wire logic RSP_VALID,
    input wire logic [15:0] RSP_DATA
);
    initial begin
        CMD = '0;
        CMD_VALID = 1'b0;
    end

    // Released command lines flip so a stale value is never mistaken for a request
    task automatic send(input cmd_op_e op, input logic bf, input logic [3:0] idx,
                        input logic [15:0] d);
        @(posedge CLK);
        CMD <= '{op: op, bit_form: bf, idx: idx, data: d};
        CMD_VALID <= 1'b1;
        @(posedge CLK);
        CMD_VALID <= 1'b0;
        CMD <= ~CMD;
    endtask

    // Answer stands one cycle only, so it is taken at the next edge
    task automatic ask(input cmd_op_e op, input logic bf, input logic [3:0] idx,
                       output logic [15:0] d, output logic ok);
        send(op, bf, idx, 16'h0000);
        @(posedge CLK);
        ok = RSP_VALID;
        d = RSP_DATA;
    endtask
endmodule // host_model

// file: testbench.sv
// Command-level testbench for the panel control and status block
`timescale 1ns/1ps
module testbench;
    import panel_status_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic cold_resetn = 1'b0;
    logic ce = 1'b1;
    cmd_s cmd;
    logic cmd_valid;
    event_src_s evt = '0;
    logic scan_idle = 1'b1;
    logic iface_ready = 1'b1;
    logic out_avail = 1'b0;
    logic [2:0] pins = 3'h0;
    logic rsp_valid, srq, remote_led, panel_active, key_accept;
    logic [15:0] rsp_data;
    logic [7:0] spoll_byte;
    int errors = 0;
    int checks_done = 0;
    int key_cnt = 0;
    cmd_op_e set_ops[4] = '{OP_SRE_SET, OP_ESE_SET, OP_ERROR_ENABLE_SET, OP_LOCKIN_ENABLE_CMD_SET};
    cmd_op_e q_ops[4] = '{OP_SRE_Q, OP_ESE_Q, OP_ERROR_ENABLE_Q, OP_LOCKIN_ENABLE_CMD_Q};
    logic [15:0] v;
    logic [3:0] ix;

    always #50 clk = ~clk;
    always @(posedge clk) if (key_accept === 1'b1) key_cnt++;

    panel_status u_dut (.CLK(clk), .RESETN(resetn), .COLD_RESETN(cold_resetn), .CE(ce),
        .CMD(cmd), .CMD_VALID(cmd_valid), .EVT(evt), .SCAN_IDLE(scan_idle),
        .IFACE_READY(iface_ready), .OUT_AVAIL(out_avail), .KEY_PIN(pins[0]),
        .KNOB_PIN(pins[1]), .LOCAL_KEY_PIN(pins[2]), .RSP_VALID(rsp_valid),
        .RSP_DATA(rsp_data), .SPOLL_BYTE(spoll_byte), .SRQ(srq),
        .REMOTE_LED(remote_led), .PANEL_ACTIVE(panel_active), .KEY_ACCEPT(key_accept));
    host_model u_host (.CLK(clk), .CMD(cmd), .CMD_VALID(cmd_valid),
        .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));

    task automatic give_verdict();
        $display("Checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic q(input string name, input cmd_op_e op, input logic bf,
                     input logic [3:0] idx, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        u_host.ask(op, bf, idx, d, ok);
        chk({name, " valid"}, 16'h0001, {15'h0, ok});
        chk(name, exp, d);
    endtask

    task automatic s(input cmd_op_e op, input logic bf, input logic [3:0] idx,
                     input logic [15:0] d);
        u_host.send(op, bf, idx, d);
    endtask

    task automatic press(input logic [2:0] sel);
        @(posedge clk) pins <= sel;
        repeat (5) @(posedge clk);
        pins <= 3'h0;
        repeat (5) @(posedge clk);
    endtask

    task automatic pulse(input event_src_s e);
        @(posedge clk) evt <= e;
        @(posedge clk) evt <= '0;
        repeat (3) @(posedge clk);
    endtask

    task automatic do_reset(input logic cold);
        @(posedge clk);
        resetn <= 1'b0;
        cold_resetn <= ~cold;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        cold_resetn <= 1'b1;
    endtask

    task automatic panel(input logic led, input logic act, input int keys);
        repeat (3) @(posedge clk);
        chk("remote_led", {15'h0, led}, {15'h0, remote_led});
        chk("panel_active", {15'h0, act}, {15'h0, panel_active});
        chk("key_cnt", keys[15:0], key_cnt[15:0]);
    endtask

    initial begin
        do_reset(1'b1);
        q("esr", OP_ESR_Q, 1'b0, 4'h0, 16'h0080);
        q("esr", OP_ESR_Q, 1'b0, 4'h0, 16'h0000);
        q("ovr", OP_OVR_Q, 1'b0, 4'h0, 16'h0001);
        q("psc", OP_PSC_Q, 1'b0, 4'h0, 16'h0001);
        q("sre", OP_SRE_Q, 1'b0, 4'h0, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            v = (i == 3) ? 16'ha5c3 : 16'h00c3;
            ix = (i == 3) ? 4'hd : 4'h6;
            s(set_ops[i], 1'b0, 4'h0, v);
            s(set_ops[i], 1'b1, ix, {15'h0, ~v[ix]});
            v[ix] = ~v[ix];
            q("mask", q_ops[i], 1'b0, 4'h0, v);
            q("mask bit", q_ops[i], 1'b1, ix, {15'h0, v[ix]});
        end
        pulse('{8'h11, 8'h22, 16'h8001});
        q("err bit", OP_ERR_Q, 1'b1, 4'h5, 16'h0001);
        q("err", OP_ERR_Q, 1'b0, 4'h0, 16'h0002);
        q("err", OP_ERR_Q, 1'b0, 4'h0, 16'h0000);
        q("lia bit", OP_LIA_Q, 1'b1, 4'hf, 16'h0001);
        q("lia", OP_LIA_Q, 1'b0, 4'h0, 16'h0001);
        q("esr bit", OP_ESR_Q, 1'b1, 4'h4, 16'h0001);
        q("esr", OP_ESR_Q, 1'b0, 4'h0, 16'h0001);
        s(OP_SRE_SET, 1'b0, 4'h0, 16'h0004);
        s(OP_ERROR_ENABLE_SET, 1'b0, 4'h0, 16'h0004);
        pulse('{8'h00, 8'h04, 16'h0000});
        chk("spoll", 16'h0047, {8'h0, spoll_byte});
        chk("srq", 16'h0001, {15'h0, srq});
        q("stb", OP_STB_Q, 1'b0, 4'h0, 16'h0045);
        q("stb bit1", OP_STB_Q, 1'b1, 4'h1, 16'h0000);
        q("stb bit2", OP_STB_Q, 1'b1, 4'h2, 16'h0001);
        q("stb", OP_STB_Q, 1'b0, 4'h0, 16'h0045);
        s(OP_CLS, 1'b0, 4'h0, 16'h0000);
        q("err", OP_ERR_Q, 1'b0, 4'h0, 16'h0000);
        q("error_enable", OP_ERROR_ENABLE_Q, 1'b0, 4'h0, 16'h0004);
        repeat (3) @(posedge clk);
        chk("spoll", 16'h0003, {8'h0, spoll_byte});
        chk("srq", 16'h0000, {15'h0, srq});
        // Events while the enable is low are dropped, not latched late
        @(posedge clk) ce <= 1'b0;
        pulse('{8'h01, 8'h04, 16'h0001});
        @(posedge clk) ce <= 1'b1;
        chk("spoll frozen", 16'h0003, {8'h0, spoll_byte});
        pulse('{8'h01, 8'h00, 16'h0001});
        chk("spoll", 16'h002b, {8'h0, spoll_byte});
        s(OP_STATE_SET, 1'b0, 4'h0, 16'h0001);
        press(3'b001);
        panel(1'b1, 1'b1, 1);
        s(OP_OVR_SET, 1'b0, 4'h0, 16'h0000);
        press(3'b001);
        press(3'b010);
        panel(1'b1, 1'b0, 1);
        press(3'b100);
        press(3'b001);
        panel(1'b0, 1'b1, 2);
        q("state", OP_STATE_Q, 1'b0, 4'h0, 16'h0001);
        panel(1'b1, 1'b0, 2);
        s(OP_STATE_SET, 1'b0, 4'h0, 16'h0002);
        press(3'b100);
        press(3'b001);
        panel(1'b1, 1'b0, 2);
        s(OP_STATE_SET, 1'b0, 4'h0, 16'h0003);
        q("state", OP_STATE_Q, 1'b0, 4'h0, 16'h0002);
        s(OP_OVR_SET, 1'b0, 4'h0, 16'h0001);
        press(3'b001);
        panel(1'b1, 1'b1, 3);
        s(OP_OVR_SET, 1'b0, 4'h0, 16'h0000);
        s(OP_STATE_SET, 1'b0, 4'h0, 16'h0000);
        panel(1'b0, 1'b1, 3);
        q("urq", OP_ESR_Q, 1'b1, 4'h6, 16'h0001);
        s(OP_PSC_SET, 1'b0, 4'h0, 16'h0000);
        s(OP_ESE_SET, 1'b0, 4'h0, 16'h003c);
        do_reset(1'b0);
        q("psc", OP_PSC_Q, 1'b0, 4'h0, 16'h0000);
        q("ese", OP_ESE_Q, 1'b0, 4'h0, 16'h003c);
        q("ovr", OP_OVR_Q, 1'b0, 4'h0, 16'h0000);
        q("esr", OP_ESR_Q, 1'b0, 4'h0, 16'h0080);
        s(OP_PSC_SET, 1'b0, 4'h0, 16'h0001);
        do_reset(1'b0);
        q("ese", OP_ESE_Q, 1'b0, 4'h0, 16'h0000);
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        give_verdict();
    end
endmodule // testbench
